/* logic/ecf_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "ecf_consts.vh"
module ecf_regs (
  input  wire                     sys_clk,
  input  wire                     rst,
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [`ECF_ADDR_W-1:0]   paddr,
  input  wire [31:0]              pwdata,
  input  wire [3:0]               pstrb,
  output reg  [31:0]              prdata,
  output reg                      pready,
  output reg                      pslverr,
  input  wire                     nvm_bank_upper_err,
  input  wire                     nvm_bank_lower_err,
  input  wire                     instr_cache_source_err,
  input  wire                     sysmem_bank_c_err,
  input  wire                     sysmem_bank_b_err,
  input  wire                     sysmem_bank_a_pair_err,
  output reg                      ecc_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire                   setup_rd;
  wire                   setup_wr;
  wire                   hit_flags;
  wire                   hit_enable;
  wire                   mapped;
  wire                   lane0_wr;
  wire [`ECF_NSRC-1:0]   clr_vec;
  wire [`ECF_NSRC-1:0]   evt_vec;
  wire [`ECF_NSRC-1:0]   flags;
  reg  [`ECF_NSRC-1:0]   enable_reg;
  reg  [`ECF_NSRC-1:0]   enable_next;
  reg  [31:0]            rdata_next;

  function is_addr;
    input [`ECF_ADDR_W-1:0] a;
    input [`ECF_ADDR_W-1:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  function [31:0] pad_word;
    input [`ECF_NSRC-1:0] v;
    begin
      pad_word = {{`ECF_PAD_W{1'b0}}, v};
    end
  endfunction

  // zero-wait-state slave: answer lands in the first access cycle,
  // so read data is registered from the setup cycle
  assign setup_rd   = psel & ~penable & ~pwrite;
  assign setup_wr   = psel & penable & pwrite & pready;
  assign hit_flags  = is_addr(paddr, `ECF_OFS_FLAGS);
  assign hit_enable = is_addr(paddr, `ECF_OFS_ENABLE);
  assign mapped     = hit_flags | hit_enable;
  // upper bits live outside lane 0 and are dropped
  assign lane0_wr   = setup_wr & pstrb[0];

  // write-one clears only the addressed bits
  assign clr_vec = (lane0_wr & hit_flags) ? pwdata[`ECF_NSRC-1:0] : `ECF_FLAGS_RST;

  ////////////////////////////////////////////////////////////////////////////
  // error sources
  // upper flash bank
  assign evt_vec[`ECF_BIT_NVM_UP] = nvm_bank_upper_err;
  assign evt_vec[`ECF_BIT_NVM_LO] = nvm_bank_lower_err;
  assign evt_vec[`ECF_BIT_ICACHE] = instr_cache_source_err;
  assign evt_vec[`ECF_BIT_SYS_C]  = sysmem_bank_c_err;
  assign evt_vec[`ECF_BIT_SYS_B]  = sysmem_bank_b_err;
  assign evt_vec[`ECF_BIT_SYS_A]  = sysmem_bank_a_pair_err;

  genvar gi;
  generate
    for (gi = 0; gi < `ECF_NSRC; gi = gi + 1) begin : g_flag
      ecf_flag_bit u_flag (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .set_evt  (evt_vec[gi]),
        .clr_wr   (clr_vec[gi]),
        .flag_reg (flags[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // enable register
  always @* begin
    enable_next = enable_reg;
    if (lane0_wr & hit_enable) begin
      enable_next = pwdata[`ECF_NSRC-1:0];
    end
  end

  always @* begin
    rdata_next = `ECF_DATA_ZERO;
    if (hit_flags) begin
      rdata_next = pad_word(flags);
    end else if (hit_enable) begin
      rdata_next = pad_word(enable_reg);
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      enable_reg <= `ECF_ENABLE_RST;
      prdata     <= `ECF_DATA_ZERO;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      ecc_irq    <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      // unmapped addresses take an error response and change nothing
      pready     <= psel & ~penable;
      pslverr    <= psel & ~penable & ~mapped;
      if (setup_rd) begin
        prdata <= rdata_next;
      end
      // request from enabled flags (one cycle behind the flags)
      ecc_irq    <= |(flags & enable_reg);
    end
  end
endmodule // ecf_regs
`default_nettype wire

/* logic/ecf_consts.vh */
// How it works
// - a correctable error reported by the upper flash bank sets flag bit 5.
// - a correctable error reported by the lower flash bank sets flag bit 4.
// - a correctable error reported by the instruction cache sets flag bit 3.
// - correctable errors from sysmem banks c, b and the a pair set flag bits 2, 1 and 0.
// - a flag reads 1 while set and stays set until software writes 1 to that bit; writing 1 to other bits leaves it set.
// - enable bit 5 is read/write for the upper flash bank, resets to 0, 1 enables.
// - enable bit 4 is read/write for the lower flash bank, resets to 0, 1 enables.
// - enable bit 3 is read/write for the instruction cache, resets to 0, 1 enables.
// - enable bits 2, 1, 0 are read/write for sysmem banks c, b and a pair, reset to 0.
`ifndef ECF_CONSTS_VH
`define ECF_CONSTS_VH

`define ECF_ADDR_W        12
`define ECF_OFS_FLAGS     12'h068
`define ECF_OFS_ENABLE    12'h06C
`define ECF_NSRC          6
`define ECF_BIT_NVM_UP    5
`define ECF_BIT_NVM_LO    4
`define ECF_BIT_ICACHE    3
`define ECF_BIT_SYS_C     2
`define ECF_BIT_SYS_B     1
`define ECF_BIT_SYS_A     0
`define ECF_FLAGS_RST     6'h00
`define ECF_ENABLE_RST    6'h00
`define ECF_DATA_ZERO     32'h00000000
`define ECF_PAD_W         26

`endif

/* logic/ecf_flag_bit.v */
`timescale 1ns/1ps
`default_nettype none
module ecf_flag_bit (
  input  wire sys_clk,
  input  wire rst,
  input  wire set_evt,
  input  wire clr_wr,
  output reg  flag_reg
);
  wire flag_next;

  assign flag_next = set_evt | (flag_reg & ~clr_wr);

  always @(posedge sys_clk) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule // ecf_flag_bit
`default_nettype wire

/* dv/ecf_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ecf_regs_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ecc_irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire setup = psel && !penable;
  wire mapped = paddr == 12'h068 || paddr == 12'h06C;
  AST_RDY: assert property (setup |=> pready) else $error("no ready");
  AST_ERR: assert property (pslverr |-> pready) else $error("lone err");
  AST_UNMAP: assert property (setup && !mapped |=> pslverr) else $error("no err");
  AST_MAP: assert property (setup && mapped |=> !pslverr) else $error("bad err");
  AST_RSV: assert property (pready && !pwrite |-> !(|prdata[31:6])) else $error("rsv");
  AST_HOLD: assert property (!(setup && !pwrite) |=> $stable(prdata)) else $error("rd");
  AST_IRQ_RST: assert property ($fell(rst) |-> !ecc_irq) else $error("irq rst");
  AST_IRQ_KEEP: assert property (ecc_irq && !psel && !$past(psel) |=> ecc_irq)
    else $error("irq drop");
  COV_ERR: cover property (pslverr);
  COV_RISE: cover property ($rose(ecc_irq));
  COV_FALL: cover property ($fell(ecc_irq));
endmodule // ecf_regs_chk
bind ecf_regs ecf_regs_chk chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .ecc_irq(ecc_irq), .paddr(paddr),
  .prdata(prdata));
`default_nettype wire

/* dv/test_ecc_correctable_flags_irq_enable.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ecc_correctable_flags_irq_enable;
  logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, ecc_irq, er;
  logic [3:0]  strb = 4'hF;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [5:0]  err = 0;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  ecf_regs dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nvm_bank_upper_err(err[5]), .nvm_bank_lower_err(err[4]),
    .instr_cache_source_err(err[3]), .sysmem_bank_c_err(err[2]),
    .sysmem_bank_b_err(err[1]), .sysmem_bank_a_pair_err(err[0]), .ecc_irq(ecc_irq));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task pulse(input logic [5:0] m);
    @(posedge sys_clk) err <= m;
    @(posedge sys_clk) err <= 0;
  endtask
  task finish_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // guard far above the under two hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    rdc(12'h068, 0);
    rdc(12'h06C, 0);
    apb(1, 12'h06C, 32'hFFFFFFFF);
    rdc(12'h06C, 32'h3F);
    $display("test 1 end");
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i);
      rdc(12'h068, 32'h1 << i);
      chk(ecc_irq, 1);
      apb(1, 12'h068, 32'hFFFFFFC0);
      rdc(12'h068, 32'h1 << i);
      apb(1, 12'h068, 32'h1 << i);
      rdc(12'h068, 0);
      chk(ecc_irq, 0);
    end
    $display("test 2 end");
    // clear and new event meet at the commit edge: the event must win
    fork
      apb(1, 12'h068, 32'h00000001);
      begin
        repeat (2) @(posedge sys_clk);
        err <= 6'h01;
        @(posedge sys_clk) err <= 6'h00;
      end
    join
    rdc(12'h068, 32'h00000001);
    apb(1, 12'h06C, 0);
    pulse(6'h3F);
    rdc(12'h068, 32'h3F);
    chk(ecc_irq, 0);
    apb(1, 12'h06C, 32'h20);
    apb(0, 12'h070, 0);
    chk(er, 1);
    chk(ecc_irq, 1);
    // lane 0 off, then a write to a hole: the enables must not move
    strb <= 4'h0;
    apb(1, 12'h06C, 32'h0000003F);
    strb <= 4'hF;
    apb(1, 12'h070, 32'h0000003F);
    chk(er, 1);
    rdc(12'h06C, 32'h00000020);
    $display("test 3 end");
    // mid-run reset must drop flags, enables and the request
    @(posedge sys_clk) rst <= 1;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    rdc(12'h068, 32'h00000000);
    rdc(12'h06C, 32'h00000000);
    chk(ecc_irq, 0);
    $display("test 4 end");
    finish_test;
  end
endmodule // test_ecc_correctable_flags_irq_enable
`default_nettype wire
